// >>> hw/aux_dataset_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "aux_fifo_defines.svh"
// Operation
// - high-byte mode keeps only upper 8 bits
// - order accel X, gyro X, ... gyro Z
// - packed bytes are set one, no set two
// - timestamp and steps packed in six bytes
// - timestamp record needs enable, set-four decimation
// - step trigger picks trigger rate or steps
// - temperature set four when timestamp off, enabled
// - temperature bytes three and four only
// - temperature off when both sensors down
// - temperature rate 12.5, 26 or 52 Hz
// - temperature ready flag, optional second pin
// - 16-bit two's complement, 256 per degree
// - byte-order bit swaps high and low registers
module aux_dataset_fifo #(
  parameter int TEMP_DIV_FAST = `CLK_SYS_HZ / `TEMP_RATE_FAST_HZ,
  parameter int TEMP_DIV_MID = `CLK_SYS_HZ / `TEMP_RATE_MID_HZ,
  parameter int TEMP_DIV_SLOW = `CLK_SYS_HZ * 2 / `TEMP_RATE_SLOW_HZ_X2,
  parameter int FIFO_DEPTH = `DATA_FIFO_DEPTH
) (
  input wire logic clk_sys,                  // system clock
  input wire logic srst,                     // sync reset, high
  input wire logic onlyHighData,             // high-byte-only mode
  input wire logic [2:0] gyro_decimation_code,   // set one decimation
  input wire logic [2:0] accel_decimation_code,  // set two decimation
  input wire logic timestamp_step_batch_enable,  // timestamp record enable
  input wire logic step_trigger_select,      // 1: record per step
  input wire logic [2:0] fourth_set_decimation_code, // set four decimation
  input wire logic tempBatchEnable,          // temperature as set four
  input wire logic dataValidSelect,          // sample-valid select
  input wire logic fifoTrigger,              // trigger-rate tick, pulse
  input wire logic stepDetected,             // step event, pulse
  input wire logic [15:0] accelX,            // accel samples
  input wire logic [15:0] accelY,            // accel samples
  input wire logic [15:0] accelZ,            // accel samples
  input wire logic [15:0] gyroX,             // gyro samples
  input wire logic [15:0] gyroY,             // gyro samples
  input wire logic [15:0] gyroZ,             // gyro samples
  input wire logic [23:0] timestamp,         // timestamp counter
  input wire logic [15:0] stepCount,         // step counter
  input wire logic accelPowerDown,           // accel off
  input wire logic gyroPowerDown,            // gyro off
  input wire logic accelLowPower12Hz,        // accel 12.5 Hz low power
  input wire logic accelLowPower26Hz,        // accel 26 Hz low power
  input wire logic [15:0] tempConversion,    // temperature converter code
  input wire logic temperature_ready_routing, // route ready to pin
  input wire logic byte_order_swap,          // swap temp registers
  input wire logic regRdEn,                  // register read strobe
  input wire logic [7:0] regAddr,            // register address
  output logic [7:0] regRdData,              // register read data
  output logic temperature_ready_flag,       // new temperature data
  output logic second_interrupt_pin,         // second interrupt pin
  input wire logic fifoOutReady,             // host drains a word
  output logic fifoOutValid,                 // word available
  output logic [15:0] fifoOutWord,           // drained word
  output logic recordDropped                 // trigger lost, pulse
);
  localparam int CW = 24;
  if (TEMP_DIV_FAST < 1 || TEMP_DIV_MID < 1 || TEMP_DIV_SLOW < 1 ||
      TEMP_DIV_SLOW >= (1 << CW)) begin : g_chk
    $error("temperature divider out of range");
  end

  fifo_link_if #(.WIDTH(`DATA_FIFO_WIDTH)) lnk ();
  word_fifo #(.WIDTH(`DATA_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .lnk(lnk)
  );

  function automatic aux_fifo_pkg::dec_count_t decFactor(input logic [2:0] code);
    case (code)
      `DEC_BY2: decFactor = 6'h02;
      `DEC_BY3: decFactor = 6'h03;
      `DEC_BY4: decFactor = 6'h04;
      `DEC_BY8: decFactor = 6'h08;
      `DEC_BY16: decFactor = 6'h10;
      `DEC_BY32: decFactor = 6'h20;
      default: decFactor = 6'h01;
    endcase
  endfunction

  // temperature timebase
  logic [CW-1:0] tempCnt_ff, nxt_tempCnt, tempDiv;
  logic tempOn, tempTick;
  logic [15:0] tempData_ff, nxt_tempData;
  logic tempReady_ff, nxt_tempReady, intPin_ff, nxt_intPin;

  always_comb begin
    if (!gyroPowerDown) begin
      tempDiv = CW'(TEMP_DIV_FAST);
    end else if (accelLowPower12Hz) begin
      tempDiv = CW'(TEMP_DIV_SLOW);
    end else if (accelLowPower26Hz) begin
      tempDiv = CW'(TEMP_DIV_MID);
    end else begin
      tempDiv = CW'(TEMP_DIV_FAST);
    end
  end

  assign tempOn = !(accelPowerDown && gyroPowerDown);
  assign tempTick = tempOn && (tempCnt_ff >= tempDiv - 1'b1);

  logic readHigh;
  assign readHigh = regRdEn && (regAddr == `TEMP_HIGH_ADDR);

  always_comb begin
    nxt_tempCnt = tempCnt_ff + 1'b1;
    if (!tempOn || tempTick) begin
      nxt_tempCnt = '0;
    end
    // code is two's complement, 256 per degree, zero at 25 C
    nxt_tempData = tempTick ? tempConversion : tempData_ff;
    // a new sample wins over the clearing read
    nxt_tempReady = tempTick || (tempReady_ff && !readHigh);
    nxt_intPin = temperature_ready_routing && nxt_tempReady;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tempCnt_ff <= '0;
      tempData_ff <= `WORD_UNUSED;
      tempReady_ff <= 1'b0;
      intPin_ff <= 1'b0;
    end else begin
      tempCnt_ff <= nxt_tempCnt;
      tempData_ff <= nxt_tempData;
      tempReady_ff <= nxt_tempReady;
      intPin_ff <= nxt_intPin;
    end
  end

  assign temperature_ready_flag = tempReady_ff;
  assign second_interrupt_pin = intPin_ff;

  // register read port
  logic [7:0] rdData_ff, nxt_rdData;
  always_comb begin
    nxt_rdData = rdData_ff;
    if (regRdEn) begin
      case (regAddr)
        `TEMP_LOW_ADDR: nxt_rdData = byte_order_swap ? tempData_ff[15:8] : tempData_ff[7:0];
        `TEMP_HIGH_ADDR: nxt_rdData = byte_order_swap ? tempData_ff[7:0] : tempData_ff[15:8];
        default: nxt_rdData = `REG_READ_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdData_ff <= `REG_READ_IDLE;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end
  assign regRdData = rdData_ff;

  // data set triggers and decimation
  logic set1Trig, set4Trig, set1Fire, set4Fire, tsMode, tempMode, launch;
  aux_fifo_pkg::dec_count_t dec1_ff, dec4_ff, nxt_dec1, nxt_dec4;
  aux_fifo_pkg::seq_e state_ff, nxt_state;

  // accel decimation must be off here; host keeps it so
  assign set1Trig = onlyHighData && (gyro_decimation_code != `DEC_OFF) && fifoTrigger;
  assign tsMode = timestamp_step_batch_enable;
  assign tempMode = !timestamp_step_batch_enable && tempBatchEnable;
  always_comb begin
    set4Trig = 1'b0;
    if (fourth_set_decimation_code != `DEC_OFF) begin
      if (tsMode && !dataValidSelect && step_trigger_select) begin
        set4Trig = stepDetected;
      end else if (tsMode || tempMode) begin
        set4Trig = fifoTrigger;
      end
    end
  end
  assign set1Fire = set1Trig && (dec1_ff == '0);
  assign set4Fire = set4Trig && (dec4_ff == '0);
  assign launch = (state_ff == aux_fifo_pkg::SEQ_IDLE) && (set1Fire || set4Fire);

  always_comb begin
    nxt_dec1 = dec1_ff;
    nxt_dec4 = dec4_ff;
    if (set1Trig) begin
      nxt_dec1 = set1Fire ? decFactor(gyro_decimation_code) - 1'b1 : dec1_ff - 1'b1;
    end
    if (set4Trig) begin
      nxt_dec4 = set4Fire ? decFactor(fourth_set_decimation_code) - 1'b1 : dec4_ff - 1'b1;
    end
  end

  // record staging: up to two six-byte records
  aux_fifo_pkg::word_t stage_ff [`STAGE_WORDS];
  aux_fifo_pkg::word_t nxt_stage [`STAGE_WORDS];
  aux_fifo_pkg::word_t rec1 [3];
  aux_fifo_pkg::word_t rec4 [3];
  logic [2:0] cnt_ff, nxt_cnt, idx_ff, nxt_idx;
  logic dropped_ff, nxt_dropped;

  always_comb begin
    // word low byte is the earlier byte of the record
    rec1[0] = {gyroX[15:8], accelX[15:8]};
    rec1[1] = {gyroY[15:8], accelY[15:8]};
    rec1[2] = {gyroZ[15:8], accelZ[15:8]};
    if (tsMode) begin
      rec4[0] = {timestamp[23:16], timestamp[15:8]};
      rec4[1] = {timestamp[7:0], `BYTE_UNUSED};
      rec4[2] = stepCount;
    end else begin
      rec4[0] = `WORD_UNUSED;
      rec4[1] = tempData_ff;
      rec4[2] = `WORD_UNUSED;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_idx = idx_ff;
    nxt_stage = stage_ff;
    // single staging buffer; triggers during a push are lost
    nxt_dropped = (state_ff == aux_fifo_pkg::SEQ_PUSH) && (set1Fire || set4Fire);
    case (state_ff)
      aux_fifo_pkg::SEQ_IDLE: begin
        if (launch) begin
          nxt_idx = '0;
          nxt_state = aux_fifo_pkg::SEQ_PUSH;
          // set two never staged in high-byte mode
          if (set1Fire) begin
            for (int i = 0; i < 3; i++) begin
              nxt_stage[i] = rec1[i];
              nxt_stage[i+3] = rec4[i];
            end
            nxt_cnt = set4Fire ? 3'(`STAGE_WORDS) : `WORDS_PER_RECORD;
          end else begin
            for (int i = 0; i < 3; i++) begin
              nxt_stage[i] = rec4[i];
            end
            nxt_cnt = `WORDS_PER_RECORD;
          end
        end
      end
      aux_fifo_pkg::SEQ_PUSH: begin
        if (lnk.wrReady) begin
          nxt_idx = idx_ff + 1'b1;
          if (idx_ff == cnt_ff - 1'b1) begin
            nxt_state = aux_fifo_pkg::SEQ_IDLE;
          end
        end
      end
      default: nxt_state = aux_fifo_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_ff <= aux_fifo_pkg::SEQ_IDLE;
      cnt_ff <= '0;
      idx_ff <= '0;
      dec1_ff <= '0;
      dec4_ff <= '0;
      dropped_ff <= 1'b0;
      for (int i = 0; i < `STAGE_WORDS; i++) begin
        stage_ff[i] <= `WORD_UNUSED;
      end
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      dec1_ff <= nxt_dec1;
      dec4_ff <= nxt_dec4;
      dropped_ff <= nxt_dropped;
      stage_ff <= nxt_stage;
    end
  end
  assign recordDropped = dropped_ff;

  // fifo fill stalls the push; output stage keeps ports registered
  assign lnk.wrValid = (state_ff == aux_fifo_pkg::SEQ_PUSH);
  assign lnk.wrData = stage_ff[idx_ff];

  logic outValid_ff, nxt_outValid;
  logic [15:0] outWord_ff, nxt_outWord;
  assign lnk.rdReady = !outValid_ff || fifoOutReady;
  always_comb begin
    nxt_outValid = outValid_ff;
    nxt_outWord = outWord_ff;
    if (lnk.rdReady) begin
      nxt_outValid = lnk.rdValid;
      if (lnk.rdValid) begin
        nxt_outWord = lnk.rdData;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      outValid_ff <= 1'b0;
      outWord_ff <= `WORD_UNUSED;
    end else begin
      outValid_ff <= nxt_outValid;
      outWord_ff <= nxt_outWord;
    end
  end
  assign fifoOutValid = outValid_ff;
  assign fifoOutWord = outWord_ff;

  // checks
  property p_tempOff;
    @(posedge clk_sys) disable iff (srst)
      (accelPowerDown && gyroPowerDown) [*2] |-> $stable(tempData_ff) && !tempTick;
  endproperty
  a_tempOff: assert property (p_tempOff) else $error("temperature sampled while off");

  property p_rateGyro;
    @(posedge clk_sys) disable iff (srst) !gyroPowerDown |-> tempDiv == CW'(TEMP_DIV_FAST);
  endproperty
  a_rateGyro: assert property (p_rateGyro) else $error("wrong rate with gyro on");

  property p_readyPin;
    @(posedge clk_sys) disable iff (srst)
      tempTick && temperature_ready_routing |=> second_interrupt_pin && temperature_ready_flag;
  endproperty
  a_readyPin: assert property (p_readyPin) else $error("ready not on pin");

  property p_swap;
    @(posedge clk_sys) disable iff (srst)
      regRdEn && regAddr == `TEMP_LOW_ADDR && byte_order_swap && !tempTick
      |=> regRdData == tempData_ff[15:8];
  endproperty
  a_swap: assert property (p_swap) else $error("low register not swapped");

  property p_highBytes;
    @(posedge clk_sys) disable iff (srst)
      launch && set1Fire |=> stage_ff[0] == {$past(gyroX[15:8]), $past(accelX[15:8])}
        && stage_ff[2] == {$past(gyroZ[15:8]), $past(accelZ[15:8])};
  endproperty
  a_highBytes: assert property (p_highBytes) else $error("high-byte record wrong");

  property p_noSetTwo;
    @(posedge clk_sys) disable iff (srst)
      launch && set1Fire && !set4Fire |=> cnt_ff == `WORDS_PER_RECORD;
  endproperty
  a_noSetTwo: assert property (p_noSetTwo) else $error("extra words staged");

  property p_stepTrig;
    @(posedge clk_sys) disable iff (srst)
      set4Fire && tsMode && !dataValidSelect && step_trigger_select |-> stepDetected;
  endproperty
  a_stepTrig: assert property (p_stepTrig) else $error("step record without step");

  property p_tempGate;
    @(posedge clk_sys) disable iff (srst) set4Fire && !tsMode |-> tempBatchEnable;
  endproperty
  a_tempGate: assert property (p_tempGate) else $error("temperature stored when disabled");

  property p_threeWords;
    @(posedge clk_sys) disable iff (srst)
      launch && !set1Fire |=> lnk.wrValid ##1 lnk.wrValid ##1 lnk.wrValid;
  endproperty
  a_threeWords: assert property (p_threeWords) else $error("record not three words");

  c_hiRecord: cover property (@(posedge clk_sys) disable iff (srst) launch && set1Fire);
  c_stepRecord: cover property (@(posedge clk_sys) disable iff (srst)
    launch && set4Fire && tsMode && step_trigger_select);
  c_tempRecord: cover property (@(posedge clk_sys) disable iff (srst) launch && tempMode);
  c_fifoFull: cover property (@(posedge clk_sys) disable iff (srst) !lnk.wrReady);
endmodule
`default_nettype wire

// >>> hw/aux_fifo_defines.svh
`ifndef AUX_FIFO_DEFINES_SVH
`define AUX_FIFO_DEFINES_SVH

// register addresses on the serial register port
`define TEMP_LOW_ADDR 8'h20
`define TEMP_HIGH_ADDR 8'h21
`define REG_READ_IDLE 8'h00

// system clock and temperature output rates
`define CLK_SYS_HZ 40000000
`define TEMP_RATE_FAST_HZ 52
`define TEMP_RATE_MID_HZ 26
`define TEMP_RATE_SLOW_HZ_X2 25

// decimation codes
`define DEC_OFF 3'h0
`define DEC_NONE 3'h1
`define DEC_BY2 3'h2
`define DEC_BY3 3'h3
`define DEC_BY4 3'h4
`define DEC_BY8 3'h5
`define DEC_BY16 3'h6
`define DEC_BY32 3'h7

// record geometry: six bytes are three words
`define WORDS_PER_RECORD 3'h3
`define STAGE_WORDS 6
`define BYTE_UNUSED 8'h00
`define WORD_UNUSED 16'h0000

// data fifo
`define DATA_FIFO_WIDTH 16
`define DATA_FIFO_DEPTH 8

`endif

// >>> hw/aux_fifo_pkg.sv
package aux_fifo_pkg;
  typedef logic [15:0] word_t;
  typedef logic [5:0] dec_count_t;
  typedef enum logic {SEQ_IDLE, SEQ_PUSH} seq_e;
endpackage

// >>> hw/fifo_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fifo_link_if #(parameter int WIDTH = 16);
  logic wrValid;
  logic wrReady;
  logic [WIDTH-1:0] wrData;
  logic rdValid;
  logic rdReady;
  logic [WIDTH-1:0] rdData;
  modport user (output wrValid, output wrData, input wrReady,
                input rdValid, input rdData, output rdReady);
  modport store (input wrValid, input wrData, output wrReady,
                 output rdValid, output rdData, input rdReady);
endinterface
`default_nettype wire

// >>> hw/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,   // system clock
  input wire logic srst,      // sync reset, high
  fifo_link_if.store lnk      // fill and drain sides
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("word_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_ff, rdPtr_ff, nxt_wrPtr, nxt_rdPtr;
  logic full, empty, doWr, doRd;

  assign full = (wrPtr_ff[AW] != rdPtr_ff[AW]) && (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
  assign empty = (wrPtr_ff == rdPtr_ff);
  assign lnk.wrReady = !full;
  assign lnk.rdValid = !empty;
  assign lnk.rdData = mem[rdPtr_ff[AW-1:0]];
  assign doWr = lnk.wrValid && !full;
  assign doRd = lnk.rdReady && !empty;

  always_comb begin
    nxt_wrPtr = doWr ? wrPtr_ff + 1'b1 : wrPtr_ff;
    nxt_rdPtr = doRd ? rdPtr_ff + 1'b1 : rdPtr_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
    end
  end

  // storage has no reset; pointers guard it
  always_ff @(posedge clk_sys) begin
    if (doWr) begin
      mem[wrPtr_ff[AW-1:0]] <= lnk.wrData;
    end
  end

  property p_noOverfill;
    @(posedge clk_sys) disable iff (srst) full |=> $stable(wrPtr_ff) || doRd;
  endproperty
  a_noOverfill: assert property (p_noOverfill) else $error("fifo written while full");
endmodule
`default_nettype wire

// >>> bench/host_drain.sv
`timescale 1ns/1ps
`default_nettype none
module host_drain (
  input wire logic clk_sys,           // system clock
  input wire logic srst,              // sync reset, high
  input wire logic stall,             // hold off draining
  input wire logic fifoOutValid,      // word offered
  input wire logic [15:0] fifoOutWord, // offered word
  output logic fifoOutReady           // word accepted
);
  aux_fifo_pkg::word_t got[$];
  logic [1:0] phase = 2'h0;
  // drops ready every third cycle so the device sees a slow host too
  always @(posedge clk_sys) begin
    if (fifoOutValid === 1'b1 && fifoOutReady === 1'b1) got.push_back(fifoOutWord);
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    fifoOutReady <= !srst && !stall && phase != 2'h2;
  end
endmodule
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "aux_fifo_defines.svh"
module tb;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic onlyHighData = 1'b0;
  logic [2:0] gyroDec = 3'h0;
  logic tsEn = 1'b0;
  logic stepSel = 1'b0;
  logic [2:0] dec4 = 3'h0;
  logic tempEn = 1'b0;
  logic validSel = 1'b0;
  logic fifoTrigger = 1'b0;
  logic stepDetected = 1'b0;
  logic accelDown = 1'b0;
  logic gyroDown = 1'b0;
  logic lp12 = 1'b0;
  logic lp26 = 1'b0;
  logic routing = 1'b0;
  logic swapBytes = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic stall = 1'b0;
  logic [15:0] accelX = 16'h11AA;
  logic [15:0] accelY = 16'h33CC;
  logic [15:0] accelZ = 16'h55EE;
  logic [15:0] gyroX = 16'h22BB;
  logic [15:0] gyroY = 16'h44DD;
  logic [15:0] gyroZ = 16'h66FF;
  logic [23:0] timestamp = 24'hA1B2C3;
  logic [15:0] stepCount = 16'h0456;
  logic [15:0] tempConversion = 16'hE700;
  logic [7:0] regRdData;
  logic readyFlag;
  logic intPin;
  logic fifoOutReady;
  logic fifoOutValid;
  logic [15:0] fifoOutWord;
  logic recordDropped;
  logic sawDrop = 1'b0;
  int cyc = 0;
  int n_errors = 0;
  int checks = 0;
  int t;
  aux_fifo_pkg::word_t hb[12] = '{16'h2211, 16'h4433, 16'h6655, 16'h2211, 16'h4433,
                                  16'h6655, 16'h2211, 16'h4433, 16'h6655, 16'h2211,
                                  16'h4433, 16'h6655};
  aux_fifo_pkg::word_t ts[12] = '{0: 16'hA1B2, 1: 16'hC300, 2: 16'h0456, default: 16'h0000};

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  always @(posedge clk_sys) if (recordDropped === 1'b1) sawDrop <= 1'b1;

  aux_dataset_fifo #(.TEMP_DIV_FAST(20), .TEMP_DIV_MID(40), .TEMP_DIV_SLOW(80),
                     .FIFO_DEPTH(8)) i_aux_dataset_fifo (
    .clk_sys(clk_sys), .srst(srst), .onlyHighData(onlyHighData),
    .gyro_decimation_code(gyroDec), .accel_decimation_code(3'h0),
    .timestamp_step_batch_enable(tsEn), .step_trigger_select(stepSel),
    .fourth_set_decimation_code(dec4), .tempBatchEnable(tempEn),
    .dataValidSelect(validSel), .fifoTrigger(fifoTrigger), .stepDetected(stepDetected),
    .accelX(accelX), .accelY(accelY), .accelZ(accelZ),
    .gyroX(gyroX), .gyroY(gyroY), .gyroZ(gyroZ),
    .timestamp(timestamp), .stepCount(stepCount),
    .accelPowerDown(accelDown), .gyroPowerDown(gyroDown),
    .accelLowPower12Hz(lp12), .accelLowPower26Hz(lp26), .tempConversion(tempConversion),
    .temperature_ready_routing(routing), .byte_order_swap(swapBytes),
    .regRdEn(regRdEn), .regAddr(regAddr), .regRdData(regRdData),
    .temperature_ready_flag(readyFlag), .second_interrupt_pin(intPin),
    .fifoOutReady(fifoOutReady), .fifoOutValid(fifoOutValid), .fifoOutWord(fifoOutWord),
    .recordDropped(recordDropped));

  host_drain i_host_drain (.clk_sys(clk_sys), .srst(srst), .stall(stall),
    .fifoOutValid(fifoOutValid), .fifoOutWord(fifoOutWord), .fifoOutReady(fifoOutReady));

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    n_errors++;
    $display("[ERR] %s expected done seen timeout", what);
    complete_run();
  endtask

  task automatic pulse(input bit step);
    @(posedge clk_sys);
    if (step) stepDetected <= 1'b1;
    else fifoTrigger <= 1'b1;
    @(posedge clk_sys);
    stepDetected <= 1'b0;
    fifoTrigger <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1 chk(what, {8'h00, exp}, {8'h00, regRdData});
  endtask

  // waits for a fresh rise of the ready flag, so a stale level is never timed
  task automatic wait_flag(output int at);
    int k;
    k = 0;
    while (readyFlag === 1'b1 && k < 300) begin
      @(posedge clk_sys);
      #1 k++;
    end
    while (readyFlag !== 1'b1 && k < 300) begin
      @(posedge clk_sys);
      #1 k++;
    end
    if (k >= 300) timeout("ready flag");
    at = cyc;
  endtask

  task automatic period(input int exp);
    int t1;
    int t2;
    rd(`TEMP_HIGH_ADDR, 8'hE7, "temp high");
    rd(`TEMP_HIGH_ADDR, 8'hE7, "temp high");
    wait_flag(t1);
    rd(`TEMP_HIGH_ADDR, 8'hE7, "temp high");
    wait_flag(t2);
    chk("temp period", exp[15:0], 16'(t2 - t1));
    @(posedge clk_sys);
    #1 chk("int pin", {15'h0, routing}, {15'h0, intPin});
  endtask

  task automatic take(input aux_fifo_pkg::word_t e[12], input int n);
    int k;
    k = 0;
    while (i_host_drain.got.size() < n && k < 400) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 400) timeout("fifo words");
    for (int i = 0; i < n; i++) chk("fifo word", e[i], i_host_drain.got.pop_front());
    repeat (12) @(posedge clk_sys);
    chk("extra words", 16'h0000, 16'(i_host_drain.got.size()));
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1 chk("reset read data", 16'h0000, {8'h00, regRdData});
    chk("reset flag", 16'h0000, {15'h0, readyFlag});
    chk("reset valid", 16'h0000, {15'h0, fifoOutValid});
    // temperature registers, byte order and unmapped place
    wait_flag(t);
    rd(`TEMP_LOW_ADDR, 8'h00, "temp low");
    rd(`TEMP_HIGH_ADDR, 8'hE7, "temp high");
    #1 chk("flag after read", 16'h0000, {15'h0, readyFlag});
    swapBytes <= 1'b1;
    rd(`TEMP_LOW_ADDR, 8'hE7, "swapped low");
    rd(`TEMP_HIGH_ADDR, 8'h00, "swapped high");
    swapBytes <= 1'b0;
    rd(8'h33, 8'h00, "unmapped");
    // temperature rates
    routing <= 1'b1;
    period(20);
    gyroDown <= 1'b1;
    lp12 <= 1'b1;
    period(80);
    lp12 <= 1'b0;
    lp26 <= 1'b1;
    period(40);
    lp26 <= 1'b0;
    routing <= 1'b0;
    period(20);
    accelDown <= 1'b1;
    rd(`TEMP_HIGH_ADDR, 8'hE7, "temp high");
    rd(`TEMP_HIGH_ADDR, 8'hE7, "temp high");
    repeat (200) @(posedge clk_sys);
    #1 chk("flag powered down", 16'h0000, {15'h0, readyFlag});
    accelDown <= 1'b0;
    gyroDown <= 1'b0;
    // high-byte set one, then with temperature as set four
    gyroDec <= `DEC_NONE;
    onlyHighData <= 1'b1;
    pulse(0);
    take(hb, 3);
    dec4 <= `DEC_NONE;
    tempEn <= 1'b1;
    pulse(0);
    take('{0: 16'h2211, 1: 16'h4433, 2: 16'h6655, 4: 16'hE700, default: 16'h0000}, 6);
    onlyHighData <= 1'b0;
    // set four decimated by two: triggers one and three store
    dec4 <= `DEC_BY2;
    repeat (4) begin
      pulse(0);
      repeat (8) @(posedge clk_sys);
    end
    take('{1: 16'hE700, 4: 16'hE700, default: 16'h0000}, 6);
    // timestamp and steps take precedence over temperature
    dec4 <= `DEC_NONE;
    tsEn <= 1'b1;
    pulse(0);
    take(ts, 3);
    stepSel <= 1'b1;
    pulse(0);
    take(ts, 0);
    pulse(1);
    take(ts, 3);
    validSel <= 1'b1;
    pulse(0);
    take(ts, 3);
    tsEn <= 1'b0;
    tempEn <= 1'b0;
    pulse(0);
    take(ts, 0);
    validSel <= 1'b0;
    stepSel <= 1'b0;
    dec4 <= `DEC_OFF;
    // fill the buffer with the host stalled, lose one trigger, then drain
    onlyHighData <= 1'b1;
    stall <= 1'b1;
    chk("drop before", 16'h0000, {15'h0, sawDrop});
    repeat (3) begin
      pulse(0);
      repeat (6) @(posedge clk_sys);
    end
    // nine words fill buffer and output stage; the fourth record stalls, the fifth is lost
    pulse(0);
    pulse(0);
    repeat (4) @(posedge clk_sys);
    #1 chk("valid while stalled", 16'h0001, {15'h0, fifoOutValid});
    chk("record dropped", 16'h0001, {15'h0, sawDrop});
    stall <= 1'b0;
    take(hb, 12);
    complete_run();
  end
endmodule
`default_nettype wire
